/* File: core/mrx_top.sv */
// Receive path, codec signals and APB register file
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
module mrx_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic codec_bypass_select,
  input wire logic rx_line,
  input wire logic rx_line_active,
  input wire logic col_line,
  input wire logic ext_crs,
  input wire logic ext_col,
  input wire logic ext_rxd,
  input wire logic ext_rxd_valid,
  output logic ext_transmit_bit_clock,
  input wire logic tx_active,
  output logic transmit_bit_clock,
  output logic carrier_sense,
  output logic collision,
  input wire logic fifo_ready,
  output mrx_pkg::mrx_byte_t fifo_wr,
  output logic frame_done
);
  import mrx_pkg::*;
  typedef struct packed {
    logic div;
    logic [2:0] dec_cnt;
    logic crs;
    logic col;
    logic col_prev;
    logic [1:0] col_edges;
    logic [7:0] sh;
    logic [2:0] bitn;
    logic bstb;
    logic [47:0] addr;
    logic [15:0] cnt;
    mrx_state_t st;
    logic mon;
    logic matched;
    logic col_seen;
    logic [31:0] ctrl;
    mrx_rxstat_t rxs;
    logic monitor_failure_flag;
    logic [3:0] cam_sel;
    logic [31:0] cam_lo;
    logic [15:0] cam_enable;
    logic cam_wr;
    mrx_byte_t out;
    logic done;
    logic [31:0] rdata;
  } mrx_top_st_t;
  mrx_top_st_t s_q, s_d;
  logic crs_in, col_in, rxd_in, rxv_in;
  logic cam_hit, crc_good, crc_start, crc_en;
  logic [47:0] cam_key;
  logic apb_acc, bad_frame, rej_err, mon_set;
  // [RQ5] Bypass picks the external codec
  assign crs_in = codec_bypass_select ? ext_crs : s_q.crs;
  assign col_in = codec_bypass_select ? ext_col : s_q.col;
  assign rxd_in = codec_bypass_select ? ext_rxd : rx_line;
  // Gate with activity so no stale bit is shifted as the pair goes quiet
  assign rxv_in = codec_bypass_select ? ext_rxd_valid :
                  (rx_line_active && s_q.dec_cnt == 3'(DECODE_BITS));
  assign apb_acc = psel && penable;
  assign crc_start = (s_q.st == RS_HUNT);
  assign crc_en = s_q.bstb;
  assign cam_key = {s_q.sh, s_q.addr[47:8]};
  always_comb begin
    s_d = s_q;
    s_d.bstb = 1'b0;
    s_d.out.valid = 1'b0;
    s_d.out.last = 1'b0;
    s_d.done = 1'b0;
    s_d.cam_wr = 1'b0;
    mon_set = 1'b0;
    // [RQ1] Divide by two
    s_d.div = ~s_q.div;
    // [RQ3] Carrier follows receive activity
    s_d.crs = rx_line_active;
    // [RQ2] Data valid after six bit times
    if (!rx_line_active) begin
      s_d.dec_cnt = '0;
    end else if (s_q.dec_cnt != 3'(DECODE_BITS)) begin
      s_d.dec_cnt = s_q.dec_cnt + 3'd1;
    end
    // [RQ4] Two toggles in a row mean 10 MHz
    s_d.col_prev = col_line;
    if (col_line != s_q.col_prev) begin
      s_d.col_edges = (s_q.col_edges == 2'd2) ? 2'd2 : s_q.col_edges + 2'd1;
    end else begin
      s_d.col_edges = '0;
    end
    s_d.col = (s_d.col_edges == 2'd2);
    if (col_in) begin
      s_d.col_seen = 1'b1;
    end
    // [RQ19] Byte strobe from shift register
    if (rxv_in && s_q.st != RS_IDLE) begin
      s_d.sh = {rxd_in, s_q.sh[7:1]};
      s_d.bitn = s_q.bitn + 3'd1;
      if (s_q.st != RS_HUNT && s_q.bitn == 3'd7) begin
        s_d.bstb = 1'b1;
      end
    end
    if (s_q.bstb) begin
      s_d.cnt = s_q.cnt + 16'd1;
      s_d.addr = cam_key;
    end
    rej_err = (s_q.ctrl[CTL_REJ_COL] && s_q.col_seen) ||
              (s_q.ctrl[CTL_REJ_ERR] && !crc_good);
    bad_frame = !crc_good || s_q.bitn != 3'd0 || s_q.cnt < 16'(RUNT_BYTES);
    unique case (s_q.st)
      // [RQ13] Idle until activity
      RS_IDLE: begin
        s_d.bitn = '0;
        s_d.cnt = '0;
        s_d.matched = 1'b0;
        s_d.col_seen = 1'b0;
        // [RQ23] Full duplex never monitors
        s_d.mon = tx_active && !s_q.ctrl[CTL_FDX];
        if (crs_in) begin
          s_d.st = RS_HUNT;
          s_d.sh = '0;
        end
      end
      // [RQ6] Wait for delimiter
      RS_HUNT: begin
        if (s_q.sh[7:6] == SFD_BYTE[7:6] && s_q.sh == SFD_BYTE) begin
          s_d.st = RS_ADDR;
          // First data bit is shifted in on this same edge
          s_d.bitn = 3'd1;
        end else if (!crs_in) begin
          s_d.st = RS_IDLE;
        end
      end
      RS_ADDR, RS_DATA: begin
        // [RQ7] Forward bytes after a match
        if (s_q.bstb && s_q.matched) begin
          // [RQ12] Monitoring writes nothing unless looping
          s_d.out.valid = !s_q.mon || s_q.ctrl[CTL_LOOP];
          s_d.out.data = s_q.sh;
        end
        // [RQ21] Destination first, source on transmit
        if (s_q.bstb && s_q.cnt == 16'(ADDR_BYTES - 1) && !s_q.mon) begin
          s_d.matched = cam_hit;
          // [RQ15] Unmatched destination rejected
          if (!cam_hit) begin
            s_d.rxs = '0;
            s_d.rxs.addr_miss = 1'b1;
            s_d.st = RS_DROP;
          end else begin
            s_d.st = RS_DATA;
          end
        end
        // [RQ10] Source address checked when monitoring
        if (s_q.bstb && s_q.cnt == 16'(2 * ADDR_BYTES - 1) && s_q.mon) begin
          s_d.matched = cam_hit;
          s_d.st = RS_DATA;
        end
        // [RQ14] Overrun abandons frame
        if (s_d.out.valid && !fifo_ready) begin
          s_d.out.valid = 1'b0;
          s_d.rxs = '0;
          s_d.rxs.overrun = 1'b1;
          s_d.st = RS_DROP;
        end
        // [RQ16] No resources left
        if (s_q.ctrl[CTL_NO_RES]) begin
          s_d.rxs = '0;
          s_d.rxs.no_res = 1'b1;
          s_d.st = RS_DROP;
        end
        // [RQ8] Carrier drop ends frame
        if (!crs_in) begin
          s_d.st = RS_IDLE;
          s_d.done = 1'b1;
          s_d.out.last = 1'b1;
          if (s_q.mon) begin
            // [RQ11] Monitor failure set
            if (!crc_good || !s_q.matched) begin
              s_d.monitor_failure_flag = 1'b1;
              mon_set = 1'b1;
            end
          end else begin
            // [RQ9] End-of-frame checks
            s_d.rxs.align_err = s_q.bitn != 3'd0;
            s_d.rxs.crc_err = !crc_good;
            s_d.rxs.runt = s_q.cnt < 16'(RUNT_BYTES);
            s_d.rxs.collision = s_q.col_seen;
            s_d.rxs.addr_miss = 1'b0;
            s_d.rxs.overrun = 1'b0;
            s_d.rxs.no_res = 1'b0;
            // [RQ17] Collision rejects only when enabled; CRC, alignment and runt errors always reject
            // [RQ18] Post status and reject
            s_d.rxs.rx_ok = !bad_frame && !rej_err;
          end
        end
      end
      // [RQ25] Back to idle after rejection
      RS_DROP: begin
        if (!crs_in) begin
          s_d.st = RS_IDLE;
          s_d.done = 1'b1;
        end
      end
      default: s_d.st = RS_IDLE;
    endcase
    // APB writes take effect on the access edge
    if (apb_acc && pwrite) begin
      unique case (paddr)
        REG_CTRL: s_d.ctrl = pwdata;
        // Set wins over a clear in the same cycle
        REG_TXSTAT: if (pwdata[0] && !mon_set) begin
          s_d.monitor_failure_flag = 1'b0;
        end
        REG_CAM_SEL: s_d.cam_sel = pwdata[3:0];
        REG_CAM_LO: s_d.cam_lo = pwdata;
        REG_CAM_HI: s_d.cam_wr = 1'b1;
        REG_CAM_EN: s_d.cam_enable = pwdata[15:0];
        default: ;
      endcase
    end
    unique case (paddr)
      REG_CTRL: s_d.rdata = s_q.ctrl;
      REG_RXSTAT: s_d.rdata = {24'h000000, s_q.rxs};
      REG_TXSTAT: s_d.rdata = {31'h00000000, s_q.monitor_failure_flag};
      REG_CAM_SEL: s_d.rdata = {28'h0000000, s_q.cam_sel};
      REG_CAM_LO: s_d.rdata = s_q.cam_lo;
      REG_CAM_EN: s_d.rdata = {16'h0000, s_q.cam_enable};
      default: s_d.rdata = 32'h00000000;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.st <= RS_IDLE;
      s_q.ctrl <= CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end
  mrx_crc u_crc (
    .pclk(pclk),
    .presetn(presetn),
    .start(crc_start),
    .en(crc_en),
    .din(s_q.sh),
    .good(crc_good)
  );
  mrx_cam u_cam (
    .pclk(pclk),
    .presetn(presetn),
    .wr(apb_acc && pwrite && paddr == REG_CAM_HI),
    .wsel(s_q.cam_sel),
    .wdata({pwdata[15:0], s_q.cam_lo}),
    .enable(s_q.cam_enable),
    .key(cam_key),
    .hit(cam_hit)
  );
  assign prdata = s_q.rdata;
  // Slave answers in the first access cycle; read data was registered during the setup cycle
  assign pready = apb_acc;
  assign pslverr = 1'b0;
  assign transmit_bit_clock = s_q.div;
  assign ext_transmit_bit_clock = codec_bypass_select ? s_q.div : 1'b0;
  assign carrier_sense = crs_in;
  assign collision = col_in;
  assign fifo_wr = s_q.out;
  assign frame_done = s_q.done;
endmodule : mrx_top

/* File: core/mrx_pkg.sv */
// Package: shared constants, types and register map for the receive path
// What this block does
// [RQ1] Transmit bit clock is the oscillator divided by two.
// [RQ2] Decoded data valid within six bit times; frame ends when transitions stop.
// [RQ3] Carrier sense asserted while receive pair carries data.
// [RQ4] Collision asserted when collision pair carries a 10 MHz signal.
// [RQ5] Bypass select disables codec and routes serial signals to pins.
// [RQ6] Deserializer starts after the two-bit delimiter, builds octets for FIFO. The code starts only after the whole SFD_BYTE matches.
// [RQ7] Destination compared with match table; rest forwarded only on a match.
// [RQ8] Carrier sense falling ends the frame.
// [RQ9] At frame end check alignment, CRC and runt; record status.
// [RQ10] During own transmit, run CRC check and compare source address.
// [RQ11] Bad looped-back CRC or source address sets monitor failure flag.
// [RQ12] No FIFO writes while monitoring, unless loopback mode selected.
// [RQ13] Sequencer idles on quiet network, enables FIFO writes on activity.
// [RQ14] Abandon frame if receive FIFO fills completely.
// [RQ15] Reject frame whose destination matches no table entry.
// [RQ16] Stop reception when no buffers or descriptors remain.
// [RQ17] Reject on collision only when that reject setting is on; CRC, alignment and runt errors always reject.
// [RQ18] Gather CRC and deserializer errors, reject, post receive status.
// [RQ19] Byte strobe for comparator; CRC after delimiter; alignment at carrier drop.
// [RQ20] CRC over stream compared with the final four received bytes.
// [RQ21] Latch destination on receive/loopback, source on transmit. The code compares the source whenever it is monitoring, CTL_LOOP set or not.
// [RQ22] Sixteen loadable table entries plus one fixed broadcast entry.
// [RQ23] Full duplex: no monitoring of own transmitted frames.
// [RQ24] Standard 32-bit frame check polynomial; accept only on agreement.
// [RQ25] Sequencer returns to idle after each frame ends or is rejected.
package mrx_pkg;
  localparam int unsigned OSC_HZ = 20000000;
  localparam int unsigned TXC_HZ = 10000000;
  localparam int unsigned DIV_HALF = OSC_HZ / TXC_HZ / 2;
  localparam int unsigned DECODE_BITS = 6;
  localparam int unsigned FIFO_BYTES = 32;
  localparam int unsigned CAM_ENTRIES = 16;
  localparam int unsigned ADDR_BYTES = 6;
  localparam int unsigned RUNT_BYTES = 64;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_RESIDUE = 32'hC704DD7B;
  localparam logic [47:0] BCAST_ADDR = 48'hFFFFFFFFFFFF;
  // APB offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RXSTAT = 8'h04;
  localparam logic [7:0] REG_TXSTAT = 8'h08;
  localparam logic [7:0] REG_CAM_SEL = 8'h0C;
  localparam logic [7:0] REG_CAM_LO = 8'h10;
  localparam logic [7:0] REG_CAM_HI = 8'h14;
  localparam logic [7:0] REG_CAM_EN = 8'h18;
  // Control field positions
  localparam int unsigned CTL_LOOP = 0;
  localparam int unsigned CTL_FDX = 1;
  localparam int unsigned CTL_REJ_COL = 2;
  localparam int unsigned CTL_REJ_ERR = 3;
  localparam int unsigned CTL_NO_RES = 4;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  typedef enum logic [2:0] {
    RS_IDLE, RS_HUNT, RS_ADDR, RS_DATA, RS_DROP
  } mrx_state_t;
  typedef struct packed {
    logic rx_ok;
    logic align_err;
    logic crc_err;
    logic runt;
    logic addr_miss;
    logic overrun;
    logic no_res;
    logic collision;
  } mrx_rxstat_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } mrx_byte_t;
endpackage : mrx_pkg

/* File: core/mrx_crc.sv */
// CRC-32 checker that runs one byte per strobe
`timescale 1ns/100ps
module mrx_crc (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic en,
  input wire logic [7:0] din,
  output logic good
);
  import mrx_pkg::*;
  typedef struct packed {
    logic [31:0] crc;
  } mrx_crc_st_t;
  mrx_crc_st_t s_q, s_d;
  logic [31:0] c;
  always_comb begin
    s_d = s_q;
    c = s_q.crc;
    // [RQ24] Standard polynomial
    for (int i = 0; i < 8; i++) begin
      c = (c[31] ^ din[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    if (start) begin
      s_d.crc = 32'hFFFFFFFF;
    end else if (en) begin
      s_d.crc = c;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{crc: 32'hFFFFFFFF};
    end else begin
      s_q <= s_d;
    end
  end
  // [RQ20] Residue covers final four bytes
  assign good = (s_q.crc == CRC_RESIDUE);
endmodule : mrx_crc

/* File: core/mrx_cam.sv */
// Address match table with fixed broadcast entry
`timescale 1ns/100ps
module mrx_cam #(
  parameter int unsigned N = mrx_pkg::CAM_ENTRIES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr,
  input wire logic [3:0] wsel,
  input wire logic [47:0] wdata,
  input wire logic [N-1:0] enable,
  input wire logic [47:0] key,
  output logic hit
);
  import mrx_pkg::*;
  typedef struct packed {
    logic [N-1:0][47:0] ent;
  } mrx_cam_st_t;
  mrx_cam_st_t s_q, s_d;
  logic [N-1:0] m;
  always_comb begin
    s_d = s_q;
    if (wr) begin
      s_d.ent[wsel] = wdata;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  // [RQ22] Sixteen entries plus broadcast
  for (genvar g = 0; g < N; g++) begin : g_cmp
    assign m[g] = enable[g] && (s_q.ent[g] == key);
  end
  assign hit = (|m) || (key == BCAST_ADDR);
endmodule : mrx_cam

/* File: test/mrx_monitor.sv */
// Port checker for the receive path
`timescale 1ns/100ps
module mrx_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic codec_bypass_select,
  input wire logic rx_line_active,
  input wire logic col_line,
  input wire logic ext_crs,
  input wire logic ext_col,
  input wire logic ext_transmit_bit_clock,
  input wire logic transmit_bit_clock,
  input wire logic carrier_sense,
  input wire logic collision,
  input wire logic fifo_ready,
  input wire mrx_pkg::mrx_byte_t fifo_wr,
  input wire logic frame_done
);
  import mrx_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  txc_toggle_a: assert property (
    $past(presetn) |-> transmit_bit_clock != $past(transmit_bit_clock))
    else $error("bit clock stalled");
  crs_src_a: assert property (
    !codec_bypass_select |-> carrier_sense == $past(rx_line_active))
    else $error("carrier sense wrong source");
  crs_ext_a: assert property (
    codec_bypass_select |-> carrier_sense == ext_crs)
    else $error("carrier sense not routed");
  last_end_a: assert property (
    fifo_wr.last |-> frame_done)
    else $error("last byte without frame end");
  col_ext_a: assert property (
    codec_bypass_select |-> collision == ext_col)
    else $error("collision not routed");
  txc_ext_a: assert property (
    codec_bypass_select |-> ext_transmit_bit_clock == transmit_bit_clock)
    else $error("bit clock not routed");
  col_quiet_a: assert property (
    !codec_bypass_select && $stable(col_line) && $past($stable(col_line))
    |-> !collision)
    else $error("collision on quiet pair");
  wr_room_a: assert property (
    fifo_wr.valid |-> $past(fifo_ready))
    else $error("write while fifo full");
  wr_pulse_a: assert property (
    fifo_wr.valid |=> !fifo_wr.valid [*7])
    else $error("bytes closer than eight bits");
  done_pulse_a: assert property (
    frame_done |=> !frame_done)
    else $error("frame end pulse too long");
  apb_ready_a: assert property (pready == (psel && penable))
    else $error("ready not in access cycle");
  apb_err_a: assert property (!pslverr)
    else $error("unexpected slave error");
endmodule : mrx_monitor

bind mrx_top mrx_monitor u_mrx_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .codec_bypass_select(codec_bypass_select),
  .rx_line_active(rx_line_active), .col_line(col_line),
  .ext_crs(ext_crs), .ext_col(ext_col),
  .ext_transmit_bit_clock(ext_transmit_bit_clock),
  .transmit_bit_clock(transmit_bit_clock), .carrier_sense(carrier_sense),
  .collision(collision), .fifo_ready(fifo_ready), .fifo_wr(fifo_wr),
  .frame_done(frame_done));

/* File: test/mrx_xcvr.sv */
// Transceiver model driving receive and collision pairs
`timescale 1ns/100ps
module mrx_xcvr (
  input wire logic pclk,
  output logic rx_line,
  output logic rx_line_active,
  output logic col_line
);
  logic [7:0] frm [$];
  logic busy = 0;
  logic col_on = 0;
  initial begin
    rx_line = 0;
    rx_line_active = 0;
    col_line = 0;
  end
  // Released line shows a changing pattern, never the last bit
  always @(posedge pclk) begin
    if (!busy) rx_line <= ~rx_line;
    col_line <= col_on ? ~col_line : 1'h0;
  end
  // preamble, delimiter, then bytes LSB first
  task automatic send(input logic [2:0] xb);
    logic [7:0] b;
    busy = 1;
    for (int i = -8; i < frm.size(); i++) begin
      b = (i < -1) ? 8'h55 : (i < 0) ? 8'hD5 : frm[i];
      for (int k = 0; k < 8; k++) begin
        rx_line <= b[k];
        rx_line_active <= 1'h1;
        @(posedge pclk);
      end
    end
    repeat (xb) begin
      rx_line <= 1'h1;
      @(posedge pclk);
    end
    rx_line_active <= 1'h0;
    @(posedge pclk);
    busy = 0;
  endtask : send
endmodule : mrx_xcvr

/* File: test/mrx_top_tb.sv */
// Self-checking bench for the receive path
`timescale 1ns/100ps
module mrx_top_tb;
  import mrx_pkg::*;
  typedef struct packed {
    logic [7:0] da;
    logic [4:0] ctl;
    logic txa, bad, rdy, col;
    logic [2:0] xb;
    logic [7:0] exp;
    logic [1:0] wr;
  } mrx_row_t;
  // Address byte fills destination and source; wr 2 means not judged
  localparam mrx_row_t ROWS [14] = '{
    '{8'hFF, 5'h00, 0, 0, 1, 0, 3'h0, 8'h80, 2'h1},
    '{8'h5A, 5'h00, 0, 0, 1, 0, 3'h0, 8'h80, 2'h1},
    '{8'h3C, 5'h00, 0, 0, 1, 0, 3'h0, 8'h08, 2'h0},
    '{8'h5A, 5'h00, 0, 1, 1, 0, 3'h0, 8'h20, 2'h1},
    '{8'h5A, 5'h08, 0, 1, 1, 0, 3'h0, 8'h20, 2'h2},
    '{8'h5A, 5'h00, 0, 0, 0, 0, 3'h0, 8'h04, 2'h2},
    '{8'h5A, 5'h10, 0, 0, 1, 0, 3'h0, 8'h02, 2'h2},
    '{8'h5A, 5'h04, 0, 0, 1, 1, 3'h0, 8'h01, 2'h2},
    '{8'h5A, 5'h00, 0, 0, 1, 0, 3'h4, 8'h40, 2'h1},
    '{8'h5A, 5'h00, 1, 0, 1, 0, 3'h0, 8'h00, 2'h0},
    '{8'h5A, 5'h00, 1, 1, 1, 0, 3'h0, 8'h01, 2'h0},
    '{8'h3C, 5'h00, 1, 0, 1, 0, 3'h0, 8'h01, 2'h0},
    '{8'h5A, 5'h01, 1, 0, 1, 0, 3'h0, 8'h00, 2'h1},
    '{8'h5A, 5'h02, 1, 1, 1, 0, 3'h0, 8'h00, 2'h1}};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic byp, ext_crs, ext_col, tx_active, fifo_ready, frame_done;
  logic rx_line, rx_line_active, col_line, crs, col;
  mrx_byte_t fifo_wr;
  logic [7:0] fcs_hi, lastb;
  int num_errors, total_checks, nwr, ndone, cyc;
  mrx_xcvr u_mrx_xcvr (.pclk(pclk), .rx_line(rx_line),
    .rx_line_active(rx_line_active), .col_line(col_line));
  mrx_top u_mrx_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .codec_bypass_select(byp), .rx_line(rx_line),
    .rx_line_active(rx_line_active), .col_line(col_line),
    .ext_crs(ext_crs), .ext_col(ext_col), .ext_rxd(1'h0),
    .ext_rxd_valid(1'h0), .ext_transmit_bit_clock(), .tx_active(tx_active),
    .transmit_bit_clock(), .carrier_sense(crs), .collision(col),
    .fifo_ready(fifo_ready), .fifo_wr(fifo_wr), .frame_done(frame_done));
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  // Frames take about 600 cycles; the ceiling leaves wide margin
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (fifo_wr.valid === 1'h1) begin
      nwr++;
      lastb = fifo_wr.data;
    end
    if (frame_done === 1'h1) ndone++;
    if (cyc == 40000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // reflected CRC, sent low byte first
  task automatic mk(input logic [7:0] da, input logic bad);
    logic [31:0] c;
    logic [7:0] b;
    u_mrx_xcvr.frm.delete();
    c = 32'hFFFFFFFF;
    for (int i = 0; i < 62; i++) begin
      b = i < 12 ? da : i[7:0];
      u_mrx_xcvr.frm.push_back(b);
      for (int k = 0; k < 8; k++)
        c = (c >> 1) ^ ((c[0] ^ b[k]) ? 32'hEDB88320 : 32'h0);
    end
    c = ~c ^ {31'h0, bad};
    fcs_hi = c[31:24];
    for (int k = 0; k < 4; k++) u_mrx_xcvr.frm.push_back(c[8*k +: 8]);
  endtask : mk
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {byp, ext_crs, ext_col, tx_active, fifo_ready} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    apb(0, REG_CTRL, 0);
    chk(rd, CTRL_RESET);
    apb(0, 8'h40, 0);
    chk(rd, 0);
    // entry 15 loaded but left disabled
    apb(1, REG_CAM_SEL, 0);
    apb(1, REG_CAM_LO, 32'h5A5A5A5A);
    apb(1, REG_CAM_HI, 32'h5A5A);
    apb(1, REG_CAM_SEL, 15);
    apb(1, REG_CAM_LO, 32'h3C3C3C3C);
    apb(1, REG_CAM_HI, 32'h3C3C);
    apb(1, REG_CAM_EN, 1);
    foreach (ROWS[i]) begin
      apb(1, REG_CTRL, {27'h0, ROWS[i].ctl});
      fifo_ready <= ROWS[i].rdy;
      tx_active <= ROWS[i].txa;
      u_mrx_xcvr.col_on = ROWS[i].col;
      mk(ROWS[i].da, ROWS[i].bad);
      nwr = 0;
      ndone = 0;
      @(posedge pclk);
      u_mrx_xcvr.send(ROWS[i].xb);
      u_mrx_xcvr.col_on = 0;
      for (int n = 0; n < 200 && ndone == 0; n++) @(posedge pclk);
      chk(ndone, 1);
      if (ROWS[i].wr != 2'h2) chk(nwr != 0, ROWS[i].wr);
      if (ROWS[i].wr == 2'h1) chk(lastb, fcs_hi);
      apb(0, ROWS[i].txa ? REG_TXSTAT : REG_RXSTAT, 0);
      chk(rd, ROWS[i].exp);
      apb(1, REG_TXSTAT, 1);
      $display("row %0d finished", i);
    end
    // outside codec drives sense and collision
    byp <= 1'h1;
    ext_crs <= 1'h1;
    ext_col <= 1'h1;
    repeat (2) @(posedge pclk);
    chk({crs, col}, 2'h3);
    ext_crs <= 1'h0;
    ext_col <= 1'h0;
    repeat (2) @(posedge pclk);
    chk({crs, col}, 2'h0);
    byp <= 1'h0;
    $display("bypass test finished");
    complete_run();
  end
endmodule : mrx_top_tb
